// [src/fepc_pkg.sv]
// fepc_pkg: register map, field layout and carrier types of the flash
// erase and power control block; assumes a 32-bit axi4-lite master.
package fepc_pkg;
    localparam logic [7:0] FEPC_OFS_PWR_CTRL = 8'h00;
    localparam logic [7:0] FEPC_OFS_SCTL_EXT = 8'h04;
    localparam logic [7:0] FEPC_OFS_EBS1 = 8'h08;
    localparam logic [7:0] FEPC_OFS_EBS2 = 8'h0c;
    localparam logic [7:0] FEPC_OFS_ERASE_CTRL = 8'h10;
    localparam logic [7:0] FEPC_OFS_VERIFY_ADDR = 8'h14;
    localparam logic [7:0] FEPC_OFS_VERIFY_DATA = 8'h18;
    localparam logic [7:0] FEPC_OFS_STATUS = 8'h1c;
    localparam int FEPC_PDI_BIT = 7;
    localparam int FEPC_SCX_RSVD_BIT = 7;
    localparam int FEPC_EACT_BIT = 0;
    localparam logic [7:0] FEPC_PWR_RST = 8'h00;
    localparam logic [7:0] FEPC_SCX_RST = 8'h00;
    localparam logic [7:0] FEPC_DUMMY_BYTE = 8'hff;
    localparam logic [15:0] FEPC_ERASED_WORD = 16'hffff;
    localparam logic [1:0] FEPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FEPC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } fepc_wreq_s;

    typedef enum logic [1:0] {
        FEPC_ST_IDLE = 2'b00,
        FEPC_ST_ERASE = 2'b01,
        FEPC_ST_ARMED = 2'b10
    } fepc_state_e;
endpackage

// [src/fepc_verify_unit.sv]
// fepc_verify_unit: erase stress and erase-verify of one flash array.
// assumes array word reads come back combinationally in the same cycle.
`timescale 1ns/1ps
module fepc_verify_unit
    import fepc_pkg::*;
#(
    parameter int NBLK = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // control
    input wire logic erase_en,
    input wire logic [NBLK-1:0] blk_sel,
    input wire logic dummy_wr,
    input wire logic [15:0] dummy_addr,
    // array side
    output logic [NBLK-1:0] erase_stress,
    output logic [15:0] array_addr,
    input wire logic [15:0] array_rdata,
    // result
    output logic armed,
    output logic [15:0] verify_data
);
    fepc_state_e st_ff, nxt_st;
    logic [15:0] addr_ff, nxt_addr;
    logic [15:0] vd_ff, nxt_vd;

    always_comb begin
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_vd = vd_ff;
        unique case (st_ff)
            FEPC_ST_IDLE: begin
                if (erase_en) begin
                    nxt_st = FEPC_ST_ERASE;
                end else if (dummy_wr) begin
                    nxt_st = FEPC_ST_ARMED;
                    nxt_addr = dummy_addr;
                end
            end
            FEPC_ST_ERASE: begin
                if (!erase_en) begin
                    nxt_st = FEPC_ST_IDLE;
                end
            end
            FEPC_ST_ARMED: begin
                nxt_vd = array_rdata;
                if (erase_en) begin
                    nxt_st = FEPC_ST_ERASE;
                end else if (dummy_wr) begin
                    nxt_addr = dummy_addr;
                end
            end
            default: nxt_st = FEPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_ff <= FEPC_ST_IDLE;
            addr_ff <= 16'h0000;
            vd_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            vd_ff <= nxt_vd;
        end
    end

    // stress follows erase_en directly, so clearing cuts it the same cycle
    assign erase_stress = erase_en ? blk_sel : '0;
    assign array_addr = addr_ff;
    assign armed = (st_ff == FEPC_ST_ARMED);
    assign verify_data = vd_ff;

    property p_stress_gated;
        @(posedge ref_clk) disable iff (!resetn) !erase_en |-> erase_stress == '0;
    endproperty
    a_stress_gated: assert property (p_stress_gated) else $error("stress without erase");
    property p_erase_enter;
        @(posedge ref_clk) disable iff (!resetn) erase_en |=> st_ff == FEPC_ST_ERASE;
    endproperty
    a_erase_enter: assert property (p_erase_enter) else $error("erase not entered");
    property p_stop_now;
        @(posedge ref_clk) disable iff (!resetn)
            $fell(erase_en) |-> erase_stress == '0 ##1 st_ff == FEPC_ST_IDLE;
    endproperty
    a_stop_now: assert property (p_stop_now) else $error("erase did not stop");
    property p_arm_enter;
        @(posedge ref_clk) disable iff (!resetn)
            dummy_wr && !erase_en && st_ff != FEPC_ST_ERASE |=> armed;
    endproperty
    a_arm_enter: assert property (p_arm_enter) else $error("verify not armed");
    property p_arm_addr;
        @(posedge ref_clk) disable iff (!resetn)
            dummy_wr && !erase_en && st_ff != FEPC_ST_ERASE |=> array_addr == $past(dummy_addr);
    endproperty
    a_arm_addr: assert property (p_arm_addr) else $error("verify address wrong");
    property p_vd_track;
        @(posedge ref_clk) disable iff (!resetn)
            armed && !erase_en |=> verify_data == $past(array_rdata);
    endproperty
    a_vd_track: assert property (p_vd_track) else $error("verify data stale");
endmodule

// [src/fepc_top.sv]
// fepc_top: axi4-lite register file for flash power control, erase block
// selection and erase-verify. assumes one clock, sync active-low reset.
`timescale 1ns/1ps
module fepc_top
    import fepc_pkg::*;
#(
    parameter int NBLK1 = 8,
    parameter int NBLK2 = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // chip mode
    input wire logic user_mode,
    input wire logic sub_active_req,
    // flash array
    output logic flash_pd_allow,
    output logic [NBLK1+NBLK2-1:0] erase_stress,
    output logic [15:0] array_addr,
    input wire logic [15:0] array_rdata,
    // serial control extension bits for the serial block
    output logic [6:0] sctl_ext_bits
);
    localparam int NBLK = NBLK1 + NBLK2;

    logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    fepc_wreq_s wq_ff, nxt_wq;
    logic pdi_ff, nxt_pdi;
    logic [7:0] scx_ff, nxt_scx;
    logic [NBLK1-1:0] ebs1_ff, nxt_ebs1;
    logic [NBLK2-1:0] ebs2_ff, nxt_ebs2;
    logic eact_ff, nxt_eact;
    logic dummy_wr;
    logic [15:0] dummy_addr;
    logic armed;
    logic [15:0] verify_data;
    logic do_wr;

    assign do_wr = aw_ff && w_ff && !b_ff;

    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_b = b_ff;
        nxt_wq = wq_ff;
        nxt_bresp = bresp_ff;
        nxt_pdi = pdi_ff;
        nxt_scx = scx_ff;
        nxt_ebs1 = ebs1_ff;
        nxt_ebs2 = ebs2_ff;
        nxt_eact = eact_ff;
        dummy_wr = 1'b0;
        dummy_addr = wq_ff.data[15:0];
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_wq.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wq.data = s_axi_wdata;
            nxt_wq.strb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_b = 1'b1;
            nxt_bresp = FEPC_RESP_OKAY;
            unique case (wq_ff.addr)
                FEPC_OFS_PWR_CTRL: begin
                    if (wq_ff.strb[0]) nxt_pdi = wq_ff.data[FEPC_PDI_BIT];
                end
                FEPC_OFS_SCTL_EXT: begin
                    if (wq_ff.strb[0]) nxt_scx = wq_ff.data[7:0];
                end
                // in user mode block select is frozen and the erase control is forced clear
                FEPC_OFS_EBS1: begin
                    if (!user_mode) nxt_ebs1 = wq_ff.data[NBLK1-1:0];
                end
                FEPC_OFS_EBS2: begin
                    if (!user_mode) nxt_ebs2 = wq_ff.data[NBLK2-1:0];
                end
                FEPC_OFS_ERASE_CTRL: begin
                    if (!user_mode && wq_ff.strb[0]) begin
                        nxt_eact = wq_ff.data[FEPC_EACT_BIT];
                    end
                end
                FEPC_OFS_VERIFY_ADDR: begin
                    // a dummy write arms only byte ff at an even address
                    dummy_wr = !user_mode && !eact_ff && wq_ff.data[0] == 1'b0
                        && wq_ff.data[23:16] == FEPC_DUMMY_BYTE;
                end
                FEPC_OFS_VERIFY_DATA, FEPC_OFS_STATUS: begin
                    nxt_bresp = FEPC_RESP_SLVERR;
                end
                default: nxt_bresp = FEPC_RESP_SLVERR;
            endcase
        end
        if (b_ff && s_axi_bready) begin
            nxt_b = 1'b0;
        end
        if (user_mode) begin
            nxt_eact = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b0;
            wq_ff <= '0;
            bresp_ff <= FEPC_RESP_OKAY;
            pdi_ff <= FEPC_PWR_RST[FEPC_PDI_BIT];
            scx_ff <= FEPC_SCX_RST;
            ebs1_ff <= '0;
            ebs2_ff <= '0;
            eact_ff <= 1'b0;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            b_ff <= nxt_b;
            wq_ff <= nxt_wq;
            bresp_ff <= nxt_bresp;
            pdi_ff <= nxt_pdi;
            scx_ff <= nxt_scx;
            ebs1_ff <= nxt_ebs1;
            ebs2_ff <= nxt_ebs2;
            eact_ff <= nxt_eact;
        end
    end

    assign s_axi_awready = !aw_ff && !b_ff;
    assign s_axi_wready = !w_ff && !b_ff;
    assign s_axi_bvalid = b_ff;
    assign s_axi_bresp = bresp_ff;

    // read channel
    always_comb begin
        nxt_r = r_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_r = 1'b1;
            nxt_rresp = FEPC_RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                FEPC_OFS_PWR_CTRL: nxt_rdata[FEPC_PDI_BIT] = pdi_ff;
                FEPC_OFS_SCTL_EXT: nxt_rdata[7:0] = scx_ff;
                FEPC_OFS_EBS1: nxt_rdata[NBLK1-1:0] = ebs1_ff;
                FEPC_OFS_EBS2: nxt_rdata[NBLK2-1:0] = ebs2_ff;
                FEPC_OFS_ERASE_CTRL: nxt_rdata[FEPC_EACT_BIT] = eact_ff;
                FEPC_OFS_VERIFY_ADDR: nxt_rdata[15:0] = array_addr;
                FEPC_OFS_VERIFY_DATA: nxt_rdata[15:0] = verify_data;
                FEPC_OFS_STATUS: nxt_rdata[2:0] = {user_mode, armed, eact_ff};
                default: nxt_rresp = FEPC_RESP_SLVERR;
            endcase
        end else if (r_ff && s_axi_rready) begin
            nxt_r = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= FEPC_RESP_OKAY;
        end else begin
            r_ff <= nxt_r;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_arready = !r_ff;
    assign s_axi_rvalid = r_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // the array is the caller's; power-down is only a permission
    assign flash_pd_allow = sub_active_req && !pdi_ff;
    assign sctl_ext_bits = scx_ff[6:0];

    fepc_verify_unit #(
        .NBLK(NBLK)
    ) u_verify (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .erase_en(eact_ff),
        .blk_sel({ebs2_ff, ebs1_ff}),
        .dummy_wr(dummy_wr),
        .dummy_addr(dummy_addr),
        .erase_stress(erase_stress),
        .array_addr(array_addr),
        .array_rdata(array_rdata),
        .armed(armed),
        .verify_data(verify_data)
    );

    property p_pd_block;
        @(posedge ref_clk) disable iff (!resetn) pdi_ff |-> !flash_pd_allow;
    endproperty
    a_pd_block: assert property (p_pd_block) else $error("power-down not blocked");
    property p_pd_allow;
        @(posedge ref_clk) disable iff (!resetn) sub_active_req && !pdi_ff |-> flash_pd_allow;
    endproperty
    a_pd_allow: assert property (p_pd_allow) else $error("power-down not allowed");
    property p_pwr_rsvd;
        @(posedge ref_clk) disable iff (!resetn)
            s_axi_arvalid && s_axi_arready && s_axi_araddr == FEPC_OFS_PWR_CTRL
            |=> s_axi_rdata[6:0] == 7'h00;
    endproperty
    a_pwr_rsvd: assert property (p_pwr_rsvd) else $error("reserved bits nonzero");
    property p_pwr_read;
        @(posedge ref_clk) disable iff (!resetn)
            s_axi_arvalid && s_axi_arready && s_axi_araddr == FEPC_OFS_PWR_CTRL
            |=> s_axi_rdata[FEPC_PDI_BIT] == $past(pdi_ff);
    endproperty
    a_pwr_read: assert property (p_pwr_read) else $error("inhibit read wrong");
    property p_user_no_erase;
        @(posedge ref_clk) disable iff (!resetn) user_mode |=> !eact_ff;
    endproperty
    a_user_no_erase: assert property (p_user_no_erase) else $error("erase in user mode");
    property p_user_stress;
        @(posedge ref_clk) disable iff (!resetn) user_mode |=> erase_stress == '0;
    endproperty
    a_user_stress: assert property (p_user_stress) else $error("stress in user mode");
    property p_ebs_frozen;
        @(posedge ref_clk) disable iff (!resetn)
            user_mode |=> $stable(ebs1_ff) && $stable(ebs2_ff);
    endproperty
    a_ebs_frozen: assert property (p_ebs_frozen) else $error("block select changed");
    property p_stress_only;
        @(posedge ref_clk) disable iff (!resetn) erase_stress != '0 |-> eact_ff;
    endproperty
    a_stress_only: assert property (p_stress_only) else $error("stress without erase");
    property p_wr_resp;
        @(posedge ref_clk) disable iff (!resetn) do_wr |=> s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    property p_rd_resp;
        @(posedge ref_clk) disable iff (!resetn)
            s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no read data");
    property p_vd_read;
        @(posedge ref_clk) disable iff (!resetn)
            s_axi_arvalid && s_axi_arready && s_axi_araddr == FEPC_OFS_VERIFY_DATA
            |=> s_axi_rdata[15:0] == $past(verify_data);
    endproperty
    a_vd_read: assert property (p_vd_read) else $error("verify data read wrong");
    property p_eact_hold;
        @(posedge ref_clk) disable iff (!resetn)
            eact_ff && !do_wr && !user_mode |=> eact_ff;
    endproperty
    a_eact_hold: assert property (p_eact_hold) else $error("erase dropped");
    property p_pdi_hold;
        @(posedge ref_clk) disable iff (!resetn) !do_wr |=> pdi_ff == $past(pdi_ff);
    endproperty
    a_pdi_hold: assert property (p_pdi_hold) else $error("inhibit changed");
    c_erase: cover property (@(posedge ref_clk) eact_ff ##[1:20] !eact_ff);
    c_armed: cover property (@(posedge ref_clk) armed);
    c_pd: cover property (@(posedge ref_clk) flash_pd_allow);
endmodule

// [bench/fepc_tb.sv]
// testbench: register-level regression of fepc_top over axi4-lite.
// assumes fepc_pkg offsets and combinational ready levels from the slave.
`timescale 1ns/1ps
module testbench import fepc_pkg::*; ;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic user_mode = 1'b0, sub_active_req = 1'b0, flash_pd_allow;
    logic [15:0] erase_stress, array_addr, array_rdata = 16'h0;
    logic [6:0] sctl_ext_bits;
    int fails = 0, total_checks = 0, cyc = 0;

    always #2.5 ref_clk = ~ref_clk;

    fepc_top #(.NBLK1(8), .NBLK2(8)) DUT (.ref_clk(ref_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .user_mode(user_mode), .sub_active_req(sub_active_req),
        .flash_pd_allow(flash_pd_allow), .erase_stress(erase_stress),
        .array_addr(array_addr), .array_rdata(array_rdata), .sctl_ext_bits(sctl_ext_bits));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                got = 1'b1;
            end
        end
        #1;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic got;
        got = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                got = 1'b1;
            end
        end
        #1;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, resp);
        chk_resp("write response", FEPC_RESP_OKAY, resp);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a, rd, resp);
        chk_resp("read response", FEPC_RESP_OKAY, resp);
        chk_data(what, exp, rd);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        rd_chk("power ctrl reset", FEPC_OFS_PWR_CTRL, 32'h0);
        rd_chk("sctl ext reset", FEPC_OFS_SCTL_EXT, 32'h0);
        rd_chk("status reset", FEPC_OFS_STATUS, 32'h0);
        // inhibit bit against sub-active request
        sub_active_req <= 1'b1;
        @(posedge ref_clk);
        #1 chk_data("pd allow clear", 32'h1, {31'h0, flash_pd_allow});
        wr_ok(FEPC_OFS_PWR_CTRL, 32'hffff_ffff);
        rd_chk("power ctrl low bits", FEPC_OFS_PWR_CTRL, 32'h80);
        chk_data("pd allow inhibited", 32'h0, {31'h0, flash_pd_allow});
        wr_ok(FEPC_OFS_PWR_CTRL, 32'h0);
        chk_data("pd allow again", 32'h1, {31'h0, flash_pd_allow});
        wr_ok(FEPC_OFS_SCTL_EXT, 32'h7f);
        rd_chk("sctl ext", FEPC_OFS_SCTL_EXT, 32'h7f);
        chk_data("sctl ext bits", 32'h7f, {25'h0, sctl_ext_bits});
        axi_wr(8'h20, 32'h1, resp);
        chk_resp("unmapped write", FEPC_RESP_SLVERR, resp);
        axi_wr(FEPC_OFS_VERIFY_DATA, 32'h1, resp);
        chk_resp("verify data write", FEPC_RESP_SLVERR, resp);
        // verify arm refused on wrong byte or odd address
        wr_ok(FEPC_OFS_VERIFY_ADDR, 32'h0012_0040);
        rd_chk("arm bad byte", FEPC_OFS_STATUS, 32'h0);
        wr_ok(FEPC_OFS_VERIFY_ADDR, 32'h00ff_0041);
        rd_chk("arm odd addr", FEPC_OFS_STATUS, 32'h0);
        // two blocks, one after the other, no prewrite
        wr_ok(FEPC_OFS_EBS1, 32'h01);
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h1);
        chk_data("stress block 0", 32'h0001, {16'h0, erase_stress});
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h0);
        chk_data("stress off", 32'h0, {16'h0, erase_stress});
        wr_ok(FEPC_OFS_EBS1, 32'h00);
        wr_ok(FEPC_OFS_EBS2, 32'h80);
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h1);
        chk_data("stress block 15", 32'h8000, {16'h0, erase_stress});
        rd_chk("status erasing", FEPC_OFS_STATUS, 32'h1);
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h0);
        chk_data("stress off again", 32'h0, {16'h0, erase_stress});
        // dummy write then verify read
        array_rdata <= FEPC_ERASED_WORD;
        wr_ok(FEPC_OFS_VERIFY_ADDR, 32'h00ff_0040);
        chk_data("verify addr", 32'h0040, {16'h0, array_addr});
        rd_chk("status armed", FEPC_OFS_STATUS, 32'h2);
        rd_chk("verify erased", FEPC_OFS_VERIFY_DATA, 32'hffff);
        array_rdata <= 16'h0f0f;
        repeat (2) @(posedge ref_clk);
        rd_chk("verify not erased", FEPC_OFS_VERIFY_DATA, 32'h0f0f);
        // retry after a failed verify
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h1);
        chk_data("stress retry", 32'h8000, {16'h0, erase_stress});
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h0);
        // user mode freezes block select and forces erase off
        user_mode <= 1'b1;
        wr_ok(FEPC_OFS_EBS2, 32'h01);
        rd_chk("ebs2 frozen", FEPC_OFS_EBS2, 32'h80);
        wr_ok(FEPC_OFS_ERASE_CTRL, 32'h1);
        chk_data("no user stress", 32'h0, {16'h0, erase_stress});
        axi_rd(FEPC_OFS_STATUS, rd, resp);
        chk_data("status user", 32'h4, rd & 32'h5);
        end_sim();
    end
endmodule
